// file: logic/flash_decode_pkg.sv
// Purpose: shared constants and types of the serial flash opcode decoder
// Assumes: opcodes are 8 bits, sent most significant bit first
// Notes:   frequency ceilings are whole MHz in 8-bit fields
`default_nettype none
package flash_decode_pkg;
   // operation classes
   typedef enum logic [4:0] {
      CL_NONE, CL_MAKER_SIG, CL_ELEC_SIG, CL_IDENT, CL_STAT1, CL_STAT2,
      CL_STAT_CLR, CL_BANK_RD, CL_BANK_WR, CL_LP_RD, CL_LP_NV_WR, CL_LP_V_WR,
      CL_READ, CL_FAST, CL_DDR_FAST, CL_DUAL_OUT, CL_QUAD_OUT, CL_DUAL_IO,
      CL_QUAD_IO, CL_DDR_DUAL_IO, CL_DDR_QUAD_IO, CL_PAGE_WR, CL_QUAD_PAGE_WR
   } cmd_class_t;
   // address length kind
   typedef enum logic [1:0] {AM_NONE, AM_SELECT, AM_FOUR} addr_mode_t;
   // one line of the opcode table
   typedef struct packed {
      cmd_class_t cls;
      addr_mode_t am;
      logic [7:0] mhz;
   } entry_t;
   // identification and register opcodes
   localparam logic [7:0] OP_MAKER_SIG = 8'h90, OP_IDENT = 8'h9f, OP_ELEC_SIG = 8'hab;
   localparam logic [7:0] OP_STAT1 = 8'h05, OP_STAT2 = 8'h07, OP_STAT_CLR = 8'h30;
   localparam logic [7:0] OP_BANK_RD = 8'h16, OP_BANK_WR = 8'h17, OP_BANK_LEG = 8'hb9;
   localparam logic [7:0] OP_LP_RD = 8'h41, OP_LP_NV_WR = 8'h43, OP_LP_V_WR = 8'h4a;
   // array read opcodes, selectable and four-byte forms
   localparam logic [7:0] OP_READ = 8'h03, OP_READ4 = 8'h13;
   localparam logic [7:0] OP_FAST = 8'h0b, OP_FAST4 = 8'h0c;
   localparam logic [7:0] OP_DDRF = 8'h0d, OP_DDRF4 = 8'h0e;
   localparam logic [7:0] OP_DOUT = 8'h3b, OP_DOUT4 = 8'h3c;
   localparam logic [7:0] OP_QOUT = 8'h6b, OP_QOUT4 = 8'h6c;
   localparam logic [7:0] OP_DIO = 8'hbb, OP_DIO4 = 8'hbc;
   localparam logic [7:0] OP_QIO = 8'heb, OP_QIO4 = 8'hec;
   localparam logic [7:0] OP_DDIO = 8'hbd, OP_DDIO4 = 8'hbe;
   localparam logic [7:0] OP_DQIO = 8'hed, OP_DQIO4 = 8'hee;
   // program opcodes
   localparam logic [7:0] OP_PP = 8'h02, OP_PP4 = 8'h12;
   localparam logic [7:0] OP_QPP = 8'h32, OP_QPP_ALT = 8'h38, OP_QPP4 = 8'h34;
   // clock ceilings: 133, 104, 80, 66, 50 MHz
   localparam logic [7:0] MHZ_133 = 8'h85, MHZ_104 = 8'h68, MHZ_80 = 8'h50;
   localparam logic [7:0] MHZ_66 = 8'h42, MHZ_50 = 8'h32;
   // bank register layout and reset values
   localparam int          BANK_LONG_BIT = 7;
   localparam logic [7:0]  BANK_WR_MASK  = 8'h83;
   localparam logic [7:0]  BANK_SEL_MASK = 8'h03;
   localparam logic [7:0]  BANK_RESET    = 8'h00;
   localparam logic [7:0]  LP_RESET      = 8'h00;
   localparam logic [31:0] BANK0_BASE    = 32'h00000000;
   localparam logic [31:0] BANK1_BASE    = 32'h01000000;
   localparam int          BANK_SHIFT    = 24;
   // link bit counts
   localparam logic [3:0] OPC_LAST  = 4'h7;
   localparam logic [3:0] DATA_LAST = 4'hf;
   localparam logic [3:0] DATA_WRAP = 4'h8;
   // address byte counts
   localparam logic [2:0] ADDR3 = 3'h3, ADDR4 = 3'h4, ADDR0 = 3'h0;
endpackage : flash_decode_pkg
`default_nettype wire

// file: logic/opcode_table.sv
// Purpose: maps an 8-bit opcode to its operation class and properties
// Assumes: opcode held stable by the user while read
// Notes:   opcodes outside the set come back as not known
`default_nettype none
module opcode_table
   import flash_decode_pkg::*;
(
   opcode_table_if.table_end t
);
   cmd_class_t c; // class shortcut

   // opcode lookup
   always_comb begin
      t.ent = '{CL_NONE, AM_NONE, 8'h00};
      case (t.opcode)
         OP_MAKER_SIG: t.ent = '{CL_MAKER_SIG, AM_NONE, MHZ_133};
         OP_ELEC_SIG:  t.ent = '{CL_ELEC_SIG, AM_NONE, MHZ_50};
         OP_IDENT:     t.ent = '{CL_IDENT, AM_NONE, MHZ_133};
         OP_STAT1:     t.ent = '{CL_STAT1, AM_NONE, MHZ_133};
         OP_STAT2:     t.ent = '{CL_STAT2, AM_NONE, MHZ_133};
         OP_STAT_CLR:  t.ent = '{CL_STAT_CLR, AM_NONE, MHZ_133};
         OP_BANK_RD:   t.ent = '{CL_BANK_RD, AM_NONE, MHZ_133};
         OP_BANK_WR,
         OP_BANK_LEG:  t.ent = '{CL_BANK_WR, AM_NONE, MHZ_133};
         OP_LP_RD:     t.ent = '{CL_LP_RD, AM_NONE, MHZ_133};
         OP_LP_NV_WR:  t.ent = '{CL_LP_NV_WR, AM_NONE, MHZ_133};
         OP_LP_V_WR:   t.ent = '{CL_LP_V_WR, AM_NONE, MHZ_133};
         OP_READ:      t.ent = '{CL_READ, AM_SELECT, MHZ_50};
         OP_READ4:     t.ent = '{CL_READ, AM_FOUR, MHZ_50};
         OP_FAST:      t.ent = '{CL_FAST, AM_SELECT, MHZ_133};
         OP_FAST4:     t.ent = '{CL_FAST, AM_FOUR, MHZ_133};
         OP_DDRF:      t.ent = '{CL_DDR_FAST, AM_SELECT, MHZ_66};
         OP_DDRF4:     t.ent = '{CL_DDR_FAST, AM_FOUR, MHZ_66};
         OP_DOUT:      t.ent = '{CL_DUAL_OUT, AM_SELECT, MHZ_104};
         OP_DOUT4:     t.ent = '{CL_DUAL_OUT, AM_FOUR, MHZ_104};
         OP_QOUT:      t.ent = '{CL_QUAD_OUT, AM_SELECT, MHZ_104};
         OP_QOUT4:     t.ent = '{CL_QUAD_OUT, AM_FOUR, MHZ_104};
         OP_DIO:       t.ent = '{CL_DUAL_IO, AM_SELECT, MHZ_104};
         OP_DIO4:      t.ent = '{CL_DUAL_IO, AM_FOUR, MHZ_104};
         OP_QIO:       t.ent = '{CL_QUAD_IO, AM_SELECT, MHZ_104};
         OP_QIO4:      t.ent = '{CL_QUAD_IO, AM_FOUR, MHZ_104};
         OP_DDIO:      t.ent = '{CL_DDR_DUAL_IO, AM_SELECT, MHZ_66};
         OP_DDIO4:     t.ent = '{CL_DDR_DUAL_IO, AM_FOUR, MHZ_66};
         OP_DQIO:      t.ent = '{CL_DDR_QUAD_IO, AM_SELECT, MHZ_66};
         OP_DQIO4:     t.ent = '{CL_DDR_QUAD_IO, AM_FOUR, MHZ_66};
         OP_PP:        t.ent = '{CL_PAGE_WR, AM_SELECT, MHZ_133};
         OP_PP4:       t.ent = '{CL_PAGE_WR, AM_FOUR, MHZ_133};
         OP_QPP,
         OP_QPP_ALT:   t.ent = '{CL_QUAD_PAGE_WR, AM_SELECT, MHZ_80};
         OP_QPP4:      t.ent = '{CL_QUAD_PAGE_WR, AM_FOUR, MHZ_80};
         default:      t.ent = '{CL_NONE, AM_NONE, 8'h00};
      endcase
   end

   // properties derived from the class
   always_comb begin
      c          = t.ent.cls;
      t.known    = (c != CL_NONE);
      t.has_data = (c == CL_BANK_WR) || (c == CL_LP_NV_WR) || (c == CL_LP_V_WR);
      t.drives   = (c == CL_BANK_RD) || (c == CL_LP_RD);
      t.ddr      = (c == CL_DDR_FAST) || (c == CL_DDR_DUAL_IO) || (c == CL_DDR_QUAD_IO);
      case (c)
         CL_DUAL_OUT, CL_DUAL_IO, CL_DDR_DUAL_IO:                t.lanes = 3'h2;
         CL_QUAD_OUT, CL_QUAD_IO, CL_DDR_QUAD_IO, CL_QUAD_PAGE_WR: t.lanes = 3'h4;
         CL_NONE:                                                t.lanes = 3'h0;
         default:                                                t.lanes = 3'h1;
      endcase
   end
endmodule : opcode_table
`default_nettype wire

// file: logic/opcode_table_if.sv
// Purpose: carries an opcode to the lookup table and its decoded fields back
// Assumes: the table is purely combinational
// Notes:   one user and one table end
`default_nettype none
interface opcode_table_if;
   import flash_decode_pkg::*;
   logic [7:0] opcode;   // opcode to look up
   entry_t     ent;      // class, address kind, ceiling
   logic       known;    // opcode is in the decoded set
   logic       has_data; // one data byte follows the opcode
   logic       drives;   // device returns a register byte
   logic [2:0] lanes;    // data lanes of the operation
   logic       ddr;      // double data rate
   modport table_end (input opcode, output ent, known, has_data, drives, lanes, ddr);
   modport user_end  (output opcode, input ent, known, has_data, drives, lanes, ddr);
endinterface : opcode_table_if
`default_nettype wire

// file: logic/serial_flash_opcode_decoder.sv
// Purpose: opcode decoder of a serial multi-lane flash, link side and system side
// Assumes: sck runs only while cs_n is low; io_in[0] carries opcode and data bits
// Notes:   opcode and data words cross to sys_clk by toggle events
//
// Contract
// - bank 00 maps low, 01 from 01000000
// - 90 maker signature; AB signature at 50 MHz
// - 9F identity read up to 133 MHz
// - 05, 07 status reads; 30 clears status
// - 16 reads, 17 and B9 write bank
// - 41 returns volatile learning pattern
// - 43 programs non-volatile learning copy
// - 4A loads volatile learning copy only
// - 03/13 plain read, host at 50 MHz
// - 0B/0C fast read up to 133 MHz
// - 0D/0E double rate read, 66 MHz
// - 3B/3C dual output read, 104 MHz
// - 6B/6C quad output read, 104 MHz
// - BB dual address-and-data read
// - EB/EC quad address-and-data read
// - BD/BE double rate dual io, 66 MHz
// - ED/EE double rate quad io, 66 MHz
// - 02/12 single-lane page program
// - 32, 38, 34 quad page program
// - long address bit selects four bytes
// - command framed by chip select low
// - bank register gives high address byte
`default_nettype none
module serial_flash_opcode_decoder
   import flash_decode_pkg::*;
(
   input  wire logic        sys_clk,              // system clock, 25 MHz
   input  wire logic        rstn,                 // asynchronous reset, active low
   input  wire logic        sck,                  // link serial clock
   input  wire logic        cs_n,                 // chip select, active low
   input  wire logic [3:0]  io_in,                // lane input levels
   output logic      [3:0]  io_out,               // lane output levels
   output logic      [3:0]  io_oe_n,              // lane enables, low drives
   output logic             cmd_valid,            // decoded command pulse
   output logic      [7:0]  cmd_opcode,           // opcode of that command
   output cmd_class_t       cmd_class,            // operation class
   output logic      [2:0]  addr_bytes,           // address bytes expected
   output logic      [7:0]  addr_high_byte,       // high address byte from bank
   output logic      [2:0]  data_lanes,           // data lanes
   output logic             double_rate,          // double data rate
   output logic      [7:0]  max_mhz,              // clock ceiling in MHz
   output logic             status_clear,         // clear status one pulse
   output logic      [7:0]  bank_reg,             // bank register
   output logic             long_addr_select_bit, // four-byte addressing on
   output logic      [31:0] bank_base,            // base address of the bank
   output logic      [7:0]  learning_pattern,     // volatile learning copy
   output logic      [7:0]  learning_pattern_nv   // non-volatile learning copy
);
   // system reset synchroniser
   logic       rst_meta_q;      // first stage
   logic       rst_n_q;         // released reset
   // link side state
   logic [3:0] bit_cnt_q;       // bits seen in this frame
   logic [7:0] shift_q;         // incoming bits
   logic       data_done_q;     // data byte already taken
   logic [7:0] opc_q;           // last opcode of the link
   logic       opc_tgl_q;       // flips per opcode
   logic [7:0] data_q;          // data byte after opcode
   cmd_class_t dat_kind_q;      // class that owns data_q
   logic       dat_tgl_q;       // flips per data byte
   logic [3:0] io_o_q;          // lane output flops
   logic [3:0] oe_n_q;          // lane enable flops
   logic [7:0] rd_byte;         // byte returned on reads
   // system side state
   logic [2:0] opc_sync_q;      // opcode toggle synchroniser
   logic [2:0] dat_sync_q;      // data toggle synchroniser
   logic       opc_evt;         // opcode arrived
   logic       dat_evt;         // data byte arrived
   logic       cmd_valid_q;     // command pulse
   logic [7:0] cmd_opcode_q;    // captured opcode
   cmd_class_t cmd_class_q;     // captured class
   addr_mode_t cmd_amode_q;     // captured address kind
   logic [2:0] lanes_q;         // captured lanes
   logic       ddr_q;           // captured double rate
   logic [7:0] mhz_q;           // captured ceiling
   logic       stat_clr_q;      // status clear pulse
   logic [7:0] bank_q;          // bank register
   logic [7:0] lp_vol_q;        // volatile learning pattern
   logic [7:0] lp_nv_q;         // non-volatile learning pattern

   opcode_table_if tbl ();      // lookup carrier

   assign tbl.opcode = opc_q;

   // opcode lookup
   opcode_table u_table (
      .t (tbl.table_end)
   );

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // frame bit counter, cleared by chip select high
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
      end else begin
         shift_q <= {shift_q[6:0], io_in[0]};
         // after the data byte keep counting whole bytes
         if (bit_cnt_q == DATA_LAST) begin
            bit_cnt_q <= DATA_WRAP;
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
   end

   // data byte only once per frame
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         data_done_q <= 1'b0;
      end else if (bit_cnt_q == DATA_LAST) begin
         data_done_q <= 1'b1;
      end
   end

   // opcode word and its event; survives the frame
   always_ff @(posedge sck or negedge rst_n_q) begin
      if (!rst_n_q) begin
         opc_q     <= 8'h00;
         opc_tgl_q <= 1'b0;
      end else if (bit_cnt_q == OPC_LAST) begin
         opc_q     <= {shift_q[6:0], io_in[0]};
         opc_tgl_q <= ~opc_tgl_q;
      end
   end

   // data byte for register stores; unknown opcodes take nothing
   always_ff @(posedge sck or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_q     <= 8'h00;
         dat_kind_q <= CL_NONE;
         dat_tgl_q  <= 1'b0;
      end else if (bit_cnt_q == DATA_LAST && !data_done_q && tbl.has_data) begin
         data_q     <= {shift_q[6:0], io_in[0]};
         dat_kind_q <= tbl.ent.cls;
         dat_tgl_q  <= ~dat_tgl_q;
      end
   end

   // byte returned: registers change only between frames
   always_comb begin
      if (tbl.ent.cls == CL_LP_RD) begin
         rd_byte = lp_vol_q;
      end else begin
         rd_byte = bank_q;
      end
   end

   // output lane on the falling edge; undriven unless a bank or learning pattern read
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         io_o_q <= 4'h0;
         oe_n_q <= 4'hf;
      end else if (bit_cnt_q[3] && tbl.drives) begin
         io_o_q <= {2'b00, rd_byte[~bit_cnt_q[2:0]], 1'b0};
         oe_n_q <= 4'hd;
      end else begin
         io_o_q <= 4'h0;
         oe_n_q <= 4'hf;
      end
   end

   assign io_out  = io_o_q;
   assign io_oe_n = oe_n_q;

   // toggle synchronisers into sys_clk
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         opc_sync_q <= 3'h0;
         dat_sync_q <= 3'h0;
      end else begin
         opc_sync_q <= {opc_sync_q[1:0], opc_tgl_q};
         dat_sync_q <= {dat_sync_q[1:0], dat_tgl_q};
      end
   end

   assign opc_evt = opc_sync_q[2] ^ opc_sync_q[1];
   assign dat_evt = dat_sync_q[2] ^ dat_sync_q[1];

   // capture decoded command; opc_q is stable once the event shows
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cmd_valid_q  <= 1'b0;
         cmd_opcode_q <= 8'h00;
         cmd_class_q  <= CL_NONE;
         cmd_amode_q  <= AM_NONE;
         lanes_q      <= 3'h0;
         ddr_q        <= 1'b0;
         mhz_q        <= 8'h00;
      end else begin
         cmd_valid_q <= opc_evt && tbl.known;
         if (opc_evt && tbl.known) begin
            cmd_opcode_q <= opc_q;
            cmd_class_q  <= tbl.ent.cls;
            cmd_amode_q  <= tbl.ent.am;
            lanes_q      <= tbl.lanes;
            ddr_q        <= tbl.ddr;
            mhz_q        <= tbl.ent.mhz;
         end
      end
   end

   // status clear pulse
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_clr_q <= 1'b0;
      end else begin
         stat_clr_q <= opc_evt && (tbl.ent.cls == CL_STAT_CLR);
      end
   end

   // bank register store
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bank_q <= BANK_RESET;
      end else if (dat_evt && dat_kind_q == CL_BANK_WR) begin
         bank_q <= data_q & BANK_WR_MASK;
      end
   end

   // learning pattern copies
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lp_vol_q <= LP_RESET;
         lp_nv_q  <= LP_RESET;
      end else if (dat_evt) begin
         if (dat_kind_q == CL_LP_V_WR) begin
            lp_vol_q <= data_q;
         end else if (dat_kind_q == CL_LP_NV_WR) begin
            lp_nv_q <= data_q;
         end
      end
   end

   // address length from kind and long address bit
   always_comb begin
      case (cmd_amode_q)
         AM_FOUR:   addr_bytes = ADDR4;
         AM_SELECT: addr_bytes = bank_q[BANK_LONG_BIT] ? ADDR4 : ADDR3;
         default:   addr_bytes = ADDR0;
      endcase
   end

   // high address byte comes from the bank register for three-byte forms
   always_comb begin
      if (cmd_amode_q == AM_SELECT && !bank_q[BANK_LONG_BIT]) begin
         addr_high_byte = bank_q & BANK_SEL_MASK;
      end else begin
         addr_high_byte = 8'h00;
      end
   end

   assign bank_base            = 32'(bank_q[1:0]) << BANK_SHIFT;
   assign cmd_valid            = cmd_valid_q;
   assign cmd_opcode           = cmd_opcode_q;
   assign cmd_class            = cmd_class_q;
   assign data_lanes           = lanes_q;
   assign double_rate          = ddr_q;
   assign max_mhz              = mhz_q;
   assign status_clear         = stat_clr_q;
   assign bank_reg             = bank_q;
   assign long_addr_select_bit = bank_q[BANK_LONG_BIT];
   assign learning_pattern     = lp_vol_q;
   assign learning_pattern_nv  = lp_nv_q;

   // checks on the system side
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n_q);

   sequence s_opc_evt;
      opc_sync_q[2] != opc_sync_q[1];
   endsequence

   sequence s_dat_evt(cmd_class_t k);
      (dat_sync_q[2] != dat_sync_q[1]) && (dat_kind_q == k);
   endsequence

   AST_BANK_MAP: assert property (
      (bank_q[1:0] == 2'b01 |-> bank_base == BANK1_BASE) and
      (bank_q[1:0] == 2'b00 |-> bank_base == BANK0_BASE))
      else $error("bank base address wrong");

   AST_SIG_READS: assert property (
      cmd_valid && cmd_opcode == OP_ELEC_SIG |-> cmd_class == CL_ELEC_SIG && max_mhz == MHZ_50)
      else $error("signature read decoded wrong");

   AST_IDENT: assert property (
      cmd_valid && cmd_opcode == OP_IDENT |-> cmd_class == CL_IDENT && max_mhz == MHZ_133)
      else $error("identity read decoded wrong");

   AST_STAT_CLR: assert property (
      s_opc_evt ##0 (opc_q == OP_STAT_CLR) |=> status_clear ##1 !status_clear)
      else $error("status clear pulse missing");

   AST_BANK_WR: assert property (
      s_dat_evt(CL_BANK_WR) |=> bank_reg == ($past(data_q) & BANK_WR_MASK))
      else $error("bank register not stored");

   AST_LEGACY_BANK: assert property (
      cmd_valid && cmd_opcode == OP_BANK_LEG |-> cmd_class == CL_BANK_WR)
      else $error("legacy bank opcode decoded wrong");

   AST_LP_NV: assert property (
      s_dat_evt(CL_LP_NV_WR) |=> learning_pattern_nv == $past(data_q) &&
                                 $stable(learning_pattern))
      else $error("non-volatile pattern store wrong");

   AST_LP_VOL: assert property (
      s_dat_evt(CL_LP_V_WR) |=> learning_pattern == $past(data_q) &&
                                $stable(learning_pattern_nv))
      else $error("volatile pattern store wrong");

   AST_PLAIN_READ: assert property (
      cmd_valid && cmd_class == CL_READ |-> max_mhz == MHZ_50 && data_lanes == 3'h1)
      else $error("plain read ceiling wrong");

   AST_QUAD_PP: assert property (
      cmd_valid && (cmd_opcode == OP_QPP || cmd_opcode == OP_QPP_ALT) |->
      cmd_class == CL_QUAD_PAGE_WR && addr_bytes != ADDR0 && max_mhz == MHZ_80)
      else $error("quad page program decoded wrong");

   AST_DDR_RATE: assert property (
      cmd_valid && double_rate |-> max_mhz == MHZ_66)
      else $error("double rate ceiling wrong");

   AST_ADDR_LEN: assert property (
      cmd_valid && cmd_opcode == OP_FAST |->
      addr_bytes == (long_addr_select_bit ? ADDR4 : ADDR3))
      else $error("address length wrong");

   AST_HIGH_BYTE: assert property (
      cmd_valid && addr_bytes == ADDR3 |-> addr_high_byte == (bank_reg & BANK_SEL_MASK))
      else $error("high address byte wrong");

   AST_UNKNOWN: assert property (
      s_opc_evt ##0 !tbl.known |=> !cmd_valid)
      else $error("unknown opcode reported");

   AST_IDLE_LANES: assert property (
      cs_n |-> (io_oe_n == 4'hf) && (bit_cnt_q == 4'h0))
      else $error("lanes driven outside a frame");
endmodule : serial_flash_opcode_decoder
`default_nettype wire

// file: tb/serial_flash_opcode_decoder_test.sv
// Purpose: self-checking bench of the opcode decoder
// Assumes: each frame is an opcode plus one data byte
// Notes:   bank and learning copies are modelled here
`default_nettype none
module serial_flash_opcode_decoder_test
   import flash_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rstn, sck, cs_n, mosi, cmd_valid, double_rate, status_clear;
   logic long_addr_select_bit, drv;
   logic [3:0] io_in, io_out, io_oe_n;
   logic [7:0] cmd_opcode, addr_high_byte, max_mhz, bank_reg, rd, be, lp, nv;
   logic [7:0] learning_pattern, learning_pattern_nv;
   logic [2:0] addr_bytes, data_lanes;
   logic [31:0] bank_base;
   cmd_class_t cmd_class;
   int mismatches, total_checks, nval, nclr;
   // every decoded opcode
   logic [7:0] ops[$] = '{8'h90, 8'hab, 8'h9f, 8'h05, 8'h07, 8'h30, 8'h16, 8'h17, 8'hb9,
      8'h41, 8'h43, 8'h4a, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c, 8'h6b,
      8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h02, 8'h12, 8'h32,
      8'h38, 8'h34};
   // undriven lanes toggle so no stale level is read
   assign io_in = {sck, ~sck, io_oe_n[1] ? ~sck : io_out[1], mosi};
   serial_flash_opcode_decoder serial_flash_opcode_decoder_inst (.sys_clk, .rstn, .sck,
      .cs_n, .io_in, .io_out, .io_oe_n, .cmd_valid, .cmd_opcode, .cmd_class, .addr_bytes,
      .addr_high_byte, .data_lanes, .double_rate, .max_mhz, .status_clear, .bank_reg,
      .long_addr_select_bit, .bank_base, .learning_pattern, .learning_pattern_nv);
   spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .io1(io_in[1]));
   // expected class of an opcode
   function automatic cmd_class_t ecls(input logic [7:0] o);
      case (o)
         8'h90: return CL_MAKER_SIG;
         8'hab: return CL_ELEC_SIG;
         8'h9f: return CL_IDENT;
         8'h05: return CL_STAT1;
         8'h07: return CL_STAT2;
         8'h30: return CL_STAT_CLR;
         8'h16: return CL_BANK_RD;
         8'h17, 8'hb9: return CL_BANK_WR;
         8'h41: return CL_LP_RD;
         8'h43: return CL_LP_NV_WR;
         8'h4a: return CL_LP_V_WR;
         8'h03, 8'h13: return CL_READ;
         8'h0b, 8'h0c: return CL_FAST;
         8'h0d, 8'h0e: return CL_DDR_FAST;
         8'h3b, 8'h3c: return CL_DUAL_OUT;
         8'h6b, 8'h6c: return CL_QUAD_OUT;
         8'hbb, 8'hbc: return CL_DUAL_IO;
         8'heb, 8'hec: return CL_QUAD_IO;
         8'hbd, 8'hbe: return CL_DDR_DUAL_IO;
         8'hed, 8'hee: return CL_DDR_QUAD_IO;
         8'h02, 8'h12: return CL_PAGE_WR;
         8'h32, 8'h38, 8'h34: return CL_QUAD_PAGE_WR;
         default: return CL_NONE;
      endcase
   endfunction : ecls
   // expected clock ceiling of a class
   function automatic logic [7:0] emhz(input cmd_class_t c);
      if (c inside {CL_ELEC_SIG, CL_READ}) return MHZ_50;
      if (c inside {CL_DDR_FAST, CL_DDR_DUAL_IO, CL_DDR_QUAD_IO}) return MHZ_66;
      if (c inside {CL_DUAL_OUT, CL_QUAD_OUT, CL_DUAL_IO, CL_QUAD_IO}) return MHZ_104;
      return (c == CL_QUAD_PAGE_WR) ? MHZ_80 : MHZ_133;
   endfunction : emhz
   // one comparison
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // verdict and end of run
   task automatic finish_test();
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // one framed command and all its effects
   task automatic run(input logic [7:0] o, input logic [7:0] d);
      int v0, c0;
      logic k;
      logic [2:0] ea;
      cmd_class_t c;
      k = o inside {ops};
      c = ecls(o);
      v0 = nval;
      c0 = nclr;
      drv = 1'b0;
      @(negedge sys_clk) #7 spi_host_model_inst.frame({o, d}, rd);
      repeat (8) @(negedge sys_clk);
      cmp(nval - v0, k);
      cmp(drv, k && (o == 8'h16 || o == 8'h41));
      cmp(nclr - c0, o == 8'h30);
      if (o == 8'h16) cmp(rd, be);
      if (o == 8'h41) cmp(rd, lp);
      if (o == 8'h17 || o == 8'hb9) be = d & 8'h83;
      if (o == 8'h4a) lp = d;
      if (o == 8'h43) nv = d;
      cmp(bank_reg, be);
      cmp(learning_pattern, lp);
      cmp(learning_pattern_nv, nv);
      cmp(bank_base, {6'h00, be[1:0], 24'h000000});
      cmp(long_addr_select_bit, be[7]);
      ea = (o inside {8'h13, 8'h0c, 8'h0e, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'hbe, 8'hee, 8'h12,
         8'h34}) ? 3'h4 : (c >= CL_READ ? (be[7] ? 3'h4 : 3'h3) : 3'h0);
      if (k) begin
         cmp(cmd_opcode, o);
         cmp(cmd_class, c);
         cmp(max_mhz, emhz(c));
         cmp(double_rate, c inside {CL_DDR_FAST, CL_DDR_DUAL_IO, CL_DDR_QUAD_IO});
         cmp(data_lanes, (c inside {CL_DUAL_OUT, CL_DUAL_IO, CL_DDR_DUAL_IO}) ? 3'h2 :
            (c inside {CL_QUAD_OUT, CL_QUAD_IO, CL_DDR_QUAD_IO, CL_QUAD_PAGE_WR}) ? 3'h4 : 3'h1);
         cmp(addr_bytes, ea);
         if (ea != 3'h0) cmp(addr_high_byte, ea == 3'h3 ? be & 8'h03 : 8'h00);
      end
   endtask : run
   // pulse counters and lane drive watch
   always @(negedge sys_clk) begin
      nval <= nval + (cmd_valid === 1'b1);
      nclr <= nclr + (status_clear === 1'b1);
      if (io_oe_n !== 4'hf) drv <= 1'b1;
   end
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // cuts a hang short
   initial begin
      #1000000;
      mismatches++;
      finish_test();
   end
   initial begin
      {rstn, mismatches, total_checks, nval, nclr, be, lp, nv, drv} = '0;
      void'($urandom(32'heb06a415));
      repeat (12) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      cmp(bank_reg, 8'h00);
      foreach (ops[i]) run(ops[i], 8'($urandom));
      run(8'h17, 8'hff);
      run(8'h0b, 8'h00);
      run(8'hb9, 8'h01);
      run(8'h03, 8'h00);
      run(8'h16, 8'h00);
      run(8'h35, 8'h00);
      repeat (30) run(8'($urandom), 8'($urandom));
      finish_test();
   end
endmodule : serial_flash_opcode_decoder_test
`default_nettype wire

// file: tb/spi_host_model.sv
// Purpose: host bus controller that frames one command on the link
// Assumes: the link clock stands still outside frames
// Notes:   lane one is sampled on the last eight rising link clock edges, the data byte
`default_nettype none
module spi_host_model (
   output var logic sck,  // link clock, idle low
   output var logic cs_n, // chip select, active low
   output var logic mosi, // opcode and data bits
   input  wire logic io1  // level on lane one
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle levels from time zero
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // sixteen bits msb first; an 80 ns period keeps every ceiling
   task automatic frame(input logic [15:0] w, output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         mosi = w[i];
         #40 sck = 1'b1;
         if (i < 8) rd[i] = io1;
         #40 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      mosi = ~mosi;
   endtask : frame
endmodule : spi_host_model
`default_nettype wire
